// >>> ocea_decode.sv
// instruction class decoder with effective address and alignment checks
`timescale 1ns/10ps
`default_nettype none
`include "ocea_defs.svh"

module ocea_decode (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // instruction from fetch
  input wire logic ins_valid,
  input wire logic [31:0] ins_word,
  input wire logic [31:0] ins_addr,
  // operand values and machine state
  input wire logic [31:0] gpr_a,
  input wire logic [31:0] gpr_b,
  input wire logic [31:0] link_reg,
  input wire logic [31:0] count_reg,
  input wire logic user_mode,
  input wire logic little_endian,
  // results to execution and exception logic
  output logic dec_valid,
  output ocea_pkg::ocea_class_e dec_class,
  output logic dec_exec_ok,
  output logic dec_prog_exc,
  output logic dec_priv_exc,
  output logic dec_align_exc,
  output logic [31:0] dec_exc_vector,
  output logic dec_is_mem,
  output logic dec_is_branch,
  output ocea_pkg::ocea_ea_mode_e dec_ea_mode,
  output logic [3:0] dec_op_len,
  output logic [31:0] dec_ea,
  output logic dec_misaligned,
  output logic dec_wraps,
  output logic dec_little_endian
);
  import ocea_pkg::*;

  // extended opcodes in use under primary 31, integer and memory forms
  function automatic logic f_x31_defined(input logic [9:0] xo);
    case (xo)
      10'h000, 10'h004, 10'h008, 10'h00A, 10'h00B, 10'h013, 10'h014,
      10'h017, 10'h018, 10'h01A, 10'h01C, 10'h020, 10'h028, 10'h036,
      10'h037, 10'h03C, 10'h04B, 10'h053, 10'h056, 10'h057, 10'h068,
      10'h077, 10'h07C, 10'h088, 10'h08A, 10'h090, 10'h092, 10'h096,
      10'h097, 10'h0B7, 10'h0C8, 10'h0CA, 10'h0D2, 10'h0D7, 10'h0E8,
      10'h0EA, 10'h0EB, 10'h0F2, 10'h0F6, 10'h0F7, 10'h10A, 10'h116,
      10'h117, 10'h11C, 10'h132, 10'h136, 10'h137, 10'h13C, 10'h153,
      10'h157, 10'h173, 10'h177, 10'h197, 10'h19C, 10'h1B6, 10'h1B7,
      10'h1BC, 10'h1CB, 10'h1D3, 10'h1D6, 10'h1DC, 10'h1EB, 10'h200,
      10'h215, 10'h216, 10'h217, 10'h218, 10'h236, 10'h237, 10'h253,
      10'h255, 10'h256, 10'h257, 10'h277, 10'h293, 10'h295, 10'h296,
      10'h297, 10'h2B7, 10'h2D5, 10'h2D7, 10'h2F7, 10'h316, 10'h318,
      10'h338, 10'h356, 10'h396, 10'h39A, 10'h3BA, 10'h3D6, 10'h3D7,
      10'h3F6: f_x31_defined = 1'b1;
      // overflow-enabled arithmetic forms
      10'h208, 10'h20A, 10'h228, 10'h268, 10'h288, 10'h28A, 10'h2C8,
      10'h2CA, 10'h2E8, 10'h2EA, 10'h2EB, 10'h30A, 10'h3CB,
      10'h3EB: f_x31_defined = 1'b1;
      default: f_x31_defined = 1'b0;
    endcase
  endfunction

  // extended opcodes in use under primary 19
  function automatic logic f_x19_defined(input logic [9:0] xo);
    case (xo)
      10'h000, 10'h010, 10'h021, 10'h032, 10'h081, 10'h096, 10'h0C1,
      10'h0E1, 10'h101, 10'h121, 10'h1A1, 10'h1C1,
      10'h210: f_x19_defined = 1'b1;
      default: f_x19_defined = 1'b0;
    endcase
  endfunction

  // floating arithmetic forms; dbl selects the double-precision group
  function automatic logic f_fp_defined(input logic dbl,
                                        input logic [9:0] xo);
    logic [4:0] xa;
    xa = xo[4:0];
    if (xo[4]) begin
      case (xa)
        5'h12, 5'h14, 5'h15, 5'h18, 5'h19, 5'h1C, 5'h1D, 5'h1E,
        5'h1F: f_fp_defined = dbl ? (xa != 5'h18) : 1'b1;
        5'h17, 5'h1A: f_fp_defined = dbl;
        default: f_fp_defined = 1'b0;
      endcase
    end else begin
      case (xo)
        10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020, 10'h026, 10'h028,
        10'h040, 10'h046, 10'h048, 10'h086, 10'h088, 10'h108, 10'h247,
        10'h2C7: f_fp_defined = dbl;
        default: f_fp_defined = 1'b0;
      endcase
    end
  endfunction

  // operand length of indexed memory forms; zero for non-memory
  function automatic logic [3:0] f_x31_len(input logic [9:0] xo);
    case (xo)
      10'h057, 10'h077, 10'h0D7, 10'h0F7, 10'h036, 10'h056, 10'h116,
      10'h0F6, 10'h3D6, 10'h3F6, 10'h1D6: f_x31_len = `OCEA_LEN_B;
      10'h117, 10'h137, 10'h157, 10'h177, 10'h197, 10'h1B7, 10'h316,
      10'h396: f_x31_len = `OCEA_LEN_H;
      10'h014, 10'h017, 10'h037, 10'h096, 10'h097, 10'h0B7, 10'h136,
      10'h1B6, 10'h216, 10'h217, 10'h237, 10'h296, 10'h297, 10'h2B7,
      10'h3D7: f_x31_len = `OCEA_LEN_W;
      10'h257, 10'h277, 10'h2D7, 10'h2F7: f_x31_len = `OCEA_LEN_D;
      // string transfers move a byte sequence with no alignment need
      10'h215, 10'h255, 10'h295, 10'h2D5: f_x31_len = `OCEA_LEN_B;
      default: f_x31_len = `OCEA_LEN_NONE;
    endcase
  endfunction

  // operand length of displacement memory forms, opcodes 32 to 55
  function automatic logic [3:0] f_d_len(input logic [5:0] po);
    case (po[5:1])
      5'h10, 5'h12, 5'h17, 5'h18, 5'h1A: f_d_len = `OCEA_LEN_W;
      5'h14, 5'h15, 5'h16: f_d_len = `OCEA_LEN_H;
      5'h11, 5'h13: f_d_len = `OCEA_LEN_B;
      5'h19, 5'h1B: f_d_len = `OCEA_LEN_D;
      default: f_d_len = `OCEA_LEN_NONE;
    endcase
  endfunction

  // supervisor-only indexed forms; spr moves depend on the spr number
  function automatic logic f_x31_priv(input logic [9:0] xo,
                                      input logic spr_hi);
    case (xo)
      10'h053, 10'h092, 10'h0D2, 10'h0F2, 10'h132, 10'h1D6, 10'h236,
      10'h253, 10'h293, `OCEA_XO_TLBLD, `OCEA_XO_TLBLI: f_x31_priv = 1'b1;
      `OCEA_XO_MFSPR, `OCEA_XO_MTSPR: f_x31_priv = spr_hi;
      default: f_x31_priv = 1'b0;
    endcase
  endfunction

  logic [5:0] po;
  logic [9:0] xo;
  logic [4:0] ra;
  logic all_zero;
  logic po_64only;
  logic po_unused;
  logic po_ext;
  logic ext_defined;
  logic is_tlb_load;
  logic is_sqrt;
  logic is_dform_mem;
  logic is_xform_mem;
  logic is_fp_mem;
  logic is_multi;
  logic is_string_imm;
  logic is_rel_branch;
  logic is_lr_branch;
  logic is_ctr_branch;
  logic priv_op;
  logic [31:0] d_imm;
  logic [31:0] b_imm;
  logic [31:0] bc_imm;
  logic [31:0] mem_base;
  logic [31:0] ea_imm;
  logic [31:0] ea_val;
  logic ea_misaligned;
  logic ea_wraps;
  ocea_class_e next_class;
  ocea_ea_mode_e next_mode;
  logic [3:0] next_len;
  logic next_prog;
  logic next_priv;
  logic next_align;
  logic next_mem;
  logic next_branch;

  assign po = ins_word[`OCEA_PO_HI:`OCEA_PO_LO];
  assign xo = ins_word[`OCEA_XO_HI:`OCEA_XO_LO];
  assign ra = ins_word[`OCEA_RA_HI:`OCEA_RA_LO];
  assign all_zero = ins_word == 32'h0000_0000;

  assign po_64only = po == `OCEA_OP_TDI || po == `OCEA_OP_RLD ||
                     po == `OCEA_OP_LD || po == `OCEA_OP_STD;
  // primaries 1, 4-6, 9, 22, 56, 57, 60, 61 have no instruction here
  assign po_unused = po == 6'h01 || po == 6'h04 || po == 6'h05 ||
                     po == 6'h06 || po == 6'h09 || po == 6'h16 ||
                     po == 6'h38 || po == 6'h39 || po == 6'h3C ||
                     po == 6'h3D;
  assign po_ext = po == `OCEA_OP_XL || po == `OCEA_OP_X ||
                  po == `OCEA_OP_FPS || po == `OCEA_OP_FPD;

  // 64-bit-only extended forms are simply absent from the tables
  always_comb begin
    case (po)
      `OCEA_OP_XL: ext_defined = f_x19_defined(xo);
      `OCEA_OP_X: ext_defined = f_x31_defined(xo);
      `OCEA_OP_FPS: ext_defined = f_fp_defined(1'b0, xo);
      `OCEA_OP_FPD: ext_defined = f_fp_defined(1'b1, xo);
      default: ext_defined = 1'b0;
    endcase
  end

  assign is_tlb_load = po == `OCEA_OP_X &&
                       (xo == `OCEA_XO_TLBLD || xo == `OCEA_XO_TLBLI);
  assign is_sqrt = (po == `OCEA_OP_FPS || po == `OCEA_OP_FPD) &&
                   xo[4:0] == `OCEA_XA_FSQRT;

  // precedence: all-zero, opcode 0, reserved forms, then the tables
  always_comb begin
    if (all_zero) begin
      next_class = OCEA_CLS_ILLEGAL;
    end else if (po == `OCEA_OP_RSV) begin
      next_class = OCEA_CLS_RSV_UNIMPL;
    end else if (is_tlb_load) begin
      next_class = OCEA_CLS_RSV_IMPL;
    end else if (is_sqrt) begin
      next_class = OCEA_CLS_RSV_UNIMPL;
    end else if (po_64only || po_unused) begin
      next_class = OCEA_CLS_ILLEGAL;
    end else if (po_ext && !ext_defined) begin
      next_class = OCEA_CLS_ILLEGAL;
    end else begin
      next_class = OCEA_CLS_DEFINED;
    end
  end

  // memory forms and operand length, implied by the opcode alone
  assign is_dform_mem = po[5] && f_d_len(po) != `OCEA_LEN_NONE;
  assign is_xform_mem = po == `OCEA_OP_X &&
                        f_x31_len(xo) != `OCEA_LEN_NONE;
  assign next_len = is_dform_mem ? f_d_len(po) :
                    is_xform_mem ? f_x31_len(xo) :
                    `OCEA_LEN_NONE;
  assign is_fp_mem = (is_dform_mem && po[5:4] == 2'h3) ||
                     (is_xform_mem && ((xo[9:8] == 2'h2 &&
                     xo[2:0] == 3'h7) || xo == 10'h3D7));
  assign is_multi = po == `OCEA_OP_LMW || po == `OCEA_OP_STMW ||
                    (po == `OCEA_OP_X && (xo == `OCEA_XO_LWARX ||
                    xo == `OCEA_XO_STWCX));
  assign is_string_imm = po == `OCEA_OP_X &&
                         (xo == `OCEA_XO_LSWI || xo == `OCEA_XO_STSWI);

  assign is_rel_branch = po == `OCEA_OP_B || po == `OCEA_OP_BC;
  assign is_lr_branch = po == `OCEA_OP_XL && xo == `OCEA_XO_BCLR;
  assign is_ctr_branch = po == `OCEA_OP_XL && xo == `OCEA_XO_BCCTR;

  always_comb begin
    if (is_string_imm) begin
      next_mode = OCEA_EA_REG_IND;
    end else if (is_xform_mem) begin
      next_mode = OCEA_EA_REG_IDX;
    end else if (is_dform_mem) begin
      next_mode = OCEA_EA_REG_IMM;
    end else if (is_rel_branch) begin
      next_mode = ins_word[`OCEA_AA_BIT] ? OCEA_EA_BR_ABS
                                         : OCEA_EA_BR_REL;
    end else if (is_lr_branch) begin
      next_mode = OCEA_EA_BR_LR;
    end else if (is_ctr_branch) begin
      next_mode = OCEA_EA_BR_CTR;
    end else begin
      next_mode = OCEA_EA_NONE;
    end
  end

  // a zero base field means a zero base, not register 0
  assign mem_base = (ra == 5'h00) ? 32'h0000_0000 : gpr_a;
  assign d_imm = {{16{ins_word[15]}}, ins_word[15:0]};
  assign b_imm = {{6{ins_word[25]}}, ins_word[25:2], 2'h0};
  assign bc_imm = {{16{ins_word[15]}}, ins_word[15:2], 2'h0};
  assign ea_imm = (po == `OCEA_OP_B) ? b_imm :
                  (po == `OCEA_OP_BC) ? bc_imm : d_imm;

  ocea_ea_unit u_ea (
    .mode(next_mode),
    .base(mem_base),
    .index(gpr_b),
    .imm(ea_imm),
    .cia(ins_addr),
    .lr(link_reg),
    .ctr(count_reg),
    .op_len(next_len),
    .ea(ea_val),
    .misaligned(ea_misaligned),
    .wraps(ea_wraps)
  );

  // privilege comes from the opcode and, for spr moves, the spr number, so stray reserved bits
  // can never lift a user program past its level
  assign priv_op = (po == `OCEA_OP_XL && xo == `OCEA_XO_RFI) ||
                   (po == `OCEA_OP_X &&
                   f_x31_priv(xo, ins_word[`OCEA_SPR_PRIV_BIT]));

  assign next_prog = next_class == OCEA_CLS_ILLEGAL ||
                     next_class == OCEA_CLS_RSV_UNIMPL;
  assign next_priv = !next_prog && user_mode && priv_op;
  // other misaligned integer forms are split by the load/store unit
  assign next_align = !next_prog && !next_priv &&
                      ((is_fp_mem && ea_val[1:0] != 2'h0) ||
                      (is_multi && ea_val[1:0] != 2'h0));
  // an illegal word reaches no unit, so no other state can change
  assign next_mem = !next_prog && (is_dform_mem || is_xform_mem);
  assign next_branch = !next_prog && next_mode[2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_class <= OCEA_CLS_DEFINED;
      dec_exec_ok <= 1'b0;
      dec_prog_exc <= 1'b0;
      dec_priv_exc <= 1'b0;
      dec_align_exc <= 1'b0;
      dec_exc_vector <= 32'h0000_0000;
    end else begin
      dec_valid <= ins_valid;
      dec_class <= next_class;
      dec_exec_ok <= ins_valid && !next_prog && !next_priv &&
                     !next_align;
      dec_prog_exc <= ins_valid && (next_prog || next_priv);
      dec_priv_exc <= ins_valid && next_priv;
      dec_align_exc <= ins_valid && next_align;
      dec_exc_vector <= (ins_valid && (next_prog || next_priv)) ?
                        `OCEA_VEC_PROGRAM : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dec_is_mem <= 1'b0;
      dec_is_branch <= 1'b0;
      dec_ea_mode <= OCEA_EA_NONE;
      dec_op_len <= `OCEA_LEN_NONE;
      dec_ea <= 32'h0000_0000;
      dec_misaligned <= 1'b0;
      dec_wraps <= 1'b0;
      dec_little_endian <= 1'b0;
    end else begin
      dec_is_mem <= ins_valid && next_mem;
      dec_is_branch <= ins_valid && next_branch;
      dec_ea_mode <= next_mode;
      dec_op_len <= next_len;
      dec_ea <= ea_val;
      dec_misaligned <= ins_valid && next_mem && ea_misaligned;
      dec_wraps <= ins_valid && next_mem && ea_wraps;
      // big-endian unless the machine state selects little-endian
      dec_little_endian <= little_endian;
    end
  end
endmodule

`default_nettype wire

// >>> ocea_decode_monitor.sv
// assertion checker bound to the opcode class and address decoder
`timescale 1ns/10ps
`default_nettype none
module ocea_decode_monitor
  import ocea_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fetch side
  input wire logic ins_valid,
  input wire logic [31:0] ins_word,
  input wire logic [31:0] gpr_a,
  input wire logic [31:0] link_reg,
  input wire logic user_mode,
  // decode results
  input wire logic dec_valid,
  input wire ocea_pkg::ocea_class_e dec_class,
  input wire logic dec_exec_ok,
  input wire logic dec_prog_exc,
  input wire logic dec_priv_exc,
  input wire logic [31:0] dec_exc_vector,
  input wire logic dec_is_mem,
  input wire logic dec_is_branch,
  input wire ocea_pkg::ocea_ea_mode_e dec_ea_mode,
  input wire logic [3:0] dec_op_len,
  input wire logic [31:0] dec_ea,
  input wire logic dec_misaligned
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [5:0] po = ins_word[31:26];
  wire [9:0] xo = ins_word[10:1];
  logic [31:0] exp_ea;
  // own displacement sum, so an adder slip in the design cannot hide
  always_ff @(posedge ref_clk) begin
    exp_ea <= gpr_a + {{16{ins_word[15]}}, ins_word[15:0]};
  end
  AST_IDLE_QUIET: assert property (
    !ins_valid |=> !dec_valid && !dec_exec_ok && !dec_prog_exc && !dec_is_mem)
    else $error("decode flags raised without an instruction");
  AST_ZERO_ILLEGAL: assert property (
    ins_valid && ins_word == 32'h0 |=> dec_class == OCEA_CLS_ILLEGAL
    && dec_prog_exc) else $error("all-zero word not illegal");
  AST_PO_ZERO_RSV: assert property (
    ins_valid && po == 6'h00 && ins_word != 32'h0
    |=> dec_class == OCEA_CLS_RSV_UNIMPL && dec_prog_exc)
    else $error("zero primary opcode not reserved");
  AST_WIDE_ONLY: assert property (
    ins_valid && po inside {6'h02, 6'h1E, 6'h3A, 6'h3E}
    |=> dec_class == OCEA_CLS_ILLEGAL)
    else $error("wide-only opcode not illegal");
  AST_ILLEGAL_ONLY_EXC: assert property (
    dec_valid && dec_class == OCEA_CLS_ILLEGAL |-> !dec_is_mem
    && !dec_is_branch && !dec_exec_ok && dec_exc_vector == 32'h0000_0700)
    else $error("illegal word had side effects");
  AST_SQRT_RSV: assert property (
    ins_valid && (po == 6'h3B || po == 6'h3F) && ins_word[5:1] == 5'h16
    |=> dec_class == OCEA_CLS_RSV_UNIMPL && dec_prog_exc)
    else $error("square root not reserved unimplemented");
  AST_USER_NO_ESCALATE: assert property (
    ins_valid && user_mode && po == 6'h1F && (xo == 10'h3D2 || xo == 10'h3F2)
    |=> dec_priv_exc && !dec_exec_ok)
    else $error("user tlb load executed");
  AST_LR_TARGET: assert property (
    ins_valid && po == 6'h13 && xo == 10'h010 |=> dec_ea_mode == OCEA_EA_BR_LR
    && dec_ea == ($past(link_reg) & 32'hFFFF_FFFC))
    else $error("link target wrong");
  AST_DISP_SUM: assert property (
    ins_valid && po == 6'h20 && ins_word[20:16] != 5'h0
    |=> dec_ea == exp_ea && dec_op_len == 4'h4)
    else $error("displacement address wrong");
  AST_WORD_ALIGN: assert property (
    dec_valid && dec_is_mem && dec_op_len == 4'h4
    |-> dec_misaligned == (dec_ea[1:0] != 2'h0))
    else $error("word misalignment flag wrong");
endmodule

bind ocea_decode ocea_decode_monitor u_mon (
  .ref_clk, .rst, .ins_valid, .ins_word, .gpr_a, .link_reg, .user_mode,
  .dec_valid, .dec_class, .dec_exec_ok, .dec_prog_exc, .dec_priv_exc,
  .dec_exc_vector, .dec_is_mem, .dec_is_branch, .dec_ea_mode, .dec_op_len,
  .dec_ea, .dec_misaligned
);
`default_nettype wire

// >>> ocea_defs.svh
// constants for the opcode class and effective address checker
`ifndef OCEA_DEFS_SVH
`define OCEA_DEFS_SVH

// instruction word fields, bit 31 is the architecture's bit 0
`define OCEA_PO_HI 31
`define OCEA_PO_LO 26
`define OCEA_XO_HI 10
`define OCEA_XO_LO 1
`define OCEA_XA_HI 5
`define OCEA_RA_HI 20
`define OCEA_RA_LO 16
`define OCEA_SPR_PRIV_BIT 15
`define OCEA_AA_BIT 1

// program exception vector offset
`define OCEA_VEC_PROGRAM 32'h0000_0700

// primary opcodes
`define OCEA_OP_RSV 6'h00
`define OCEA_OP_TDI 6'h02
`define OCEA_OP_BC 6'h10
`define OCEA_OP_B 6'h12
`define OCEA_OP_XL 6'h13
`define OCEA_OP_RLD 6'h1E
`define OCEA_OP_X 6'h1F
`define OCEA_OP_LMW 6'h2E
`define OCEA_OP_STMW 6'h2F
`define OCEA_OP_LD 6'h3A
`define OCEA_OP_FPS 6'h3B
`define OCEA_OP_STD 6'h3E
`define OCEA_OP_FPD 6'h3F

// extended opcodes with special handling
`define OCEA_XO_BCLR 10'h010
`define OCEA_XO_BCCTR 10'h210
`define OCEA_XO_RFI 10'h032
`define OCEA_XO_LWARX 10'h014
`define OCEA_XO_STWCX 10'h096
`define OCEA_XO_MFSPR 10'h153
`define OCEA_XO_MTSPR 10'h1D3
`define OCEA_XO_TLBLD 10'h3D2
`define OCEA_XO_TLBLI 10'h3F2
`define OCEA_XO_LSWI 10'h255
`define OCEA_XO_STSWI 10'h2D5
`define OCEA_XA_FSQRT 5'h16

// operand lengths in bytes
`define OCEA_LEN_NONE 4'h0
`define OCEA_LEN_B 4'h1
`define OCEA_LEN_H 4'h2
`define OCEA_LEN_W 4'h4
`define OCEA_LEN_D 4'h8

`endif

// >>> ocea_ea_unit.sv
// effective address adder with wrap and natural alignment checks
`timescale 1ns/10ps
`default_nettype none
`include "ocea_defs.svh"

module ocea_ea_unit (
  // operands
  input wire ocea_pkg::ocea_ea_mode_e mode,
  input wire logic [31:0] base,
  input wire logic [31:0] index,
  input wire logic [31:0] imm,
  input wire logic [31:0] cia,
  input wire logic [31:0] lr,
  input wire logic [31:0] ctr,
  input wire logic [3:0] op_len,
  // results
  output logic [31:0] ea,
  output logic misaligned,
  output logic wraps
);
  import ocea_pkg::*;

  logic [31:0] sum_imm;
  logic [31:0] sum_idx;
  logic [31:0] sum_rel;
  logic [3:0] len_m1;
  logic [32:0] last_byte;

  // carries out of the top bit simply fall off the 32-bit sums
  assign sum_imm = base + imm;
  assign sum_idx = base + index;
  assign sum_rel = cia + imm;

  always_comb begin
    case (mode)
      OCEA_EA_REG_IMM: ea = sum_imm;
      OCEA_EA_REG_IDX: ea = sum_idx;
      OCEA_EA_REG_IND: ea = base;
      OCEA_EA_BR_REL: ea = sum_rel;
      OCEA_EA_BR_ABS: ea = imm;
      OCEA_EA_BR_LR: ea = {lr[31:2], 2'h0};
      OCEA_EA_BR_CTR: ea = {ctr[31:2], 2'h0};
      default: ea = 32'h0000_0000;
    endcase
  end

  // address names the lowest byte, so the last byte is ea plus len-1
  assign len_m1 = (op_len == `OCEA_LEN_NONE) ? 4'h0 : op_len - 4'h1;
  assign last_byte = {1'b0, ea} + {29'h0, len_m1};
  assign wraps = last_byte[32];
  assign misaligned = (ea[3:0] & len_m1) != 4'h0;
endmodule

`default_nettype wire

// >>> ocea_fetch_model.sv
// fetch stage model presenting one word with its operands per call
`timescale 1ns/10ps
`default_nettype none
module ocea_fetch_model (
  // clock
  input wire logic ref_clk,
  // instruction and operands toward the decoder
  output logic ins_valid,
  output logic [31:0] ins_word,
  output logic [31:0] ins_addr,
  output logic [31:0] gpr_a,
  output logic [31:0] gpr_b,
  output logic [31:0] link_reg,
  output logic [31:0] count_reg,
  output logic user_mode,
  output logic little_endian
);
  initial begin
    {ins_valid, user_mode, little_endian} = 3'h0;
    {ins_word, ins_addr, gpr_a, gpr_b, link_reg, count_reg} = '0;
  end
  // after the word, the word and gpr_a lines carry inverted data so late capture shows
  task automatic issue(input logic [31:0] w, input logic [31:0] pc = 32'h0,
      input logic [31:0] ra = 32'h0, input logic [31:0] rb = 32'h0,
      input logic [31:0] lr = 32'h0, input logic [31:0] ctr = 32'h0,
      input logic um = 1'b0, input logic le = 1'b0);
    @(posedge ref_clk);
    ins_valid <= 1'b1;
    ins_word <= w;
    ins_addr <= pc;
    gpr_a <= ra;
    gpr_b <= rb;
    link_reg <= lr;
    count_reg <= ctr;
    user_mode <= um;
    little_endian <= le;
    @(posedge ref_clk);
    ins_valid <= 1'b0;
    ins_word <= ~w;
    gpr_a <= ~ra;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> ocea_pkg.sv
// types shared by the opcode class and effective address checker
package ocea_pkg;
  typedef enum logic [1:0] {
    OCEA_CLS_DEFINED = 2'h0,
    OCEA_CLS_ILLEGAL = 2'h1,
    OCEA_CLS_RSV_UNIMPL = 2'h2,
    OCEA_CLS_RSV_IMPL = 2'h3
  } ocea_class_e;

  typedef enum logic [2:0] {
    OCEA_EA_NONE = 3'h0,
    OCEA_EA_REG_IMM = 3'h1,
    OCEA_EA_REG_IDX = 3'h2,
    OCEA_EA_REG_IND = 3'h3,
    OCEA_EA_BR_REL = 3'h4,
    OCEA_EA_BR_ABS = 3'h5,
    OCEA_EA_BR_LR = 3'h6,
    OCEA_EA_BR_CTR = 3'h7
  } ocea_ea_mode_e;
endpackage

// >>> tb_opcode_class_and_ea_check.sv
// self-checking bench for the opcode class and address decoder
`timescale 1ns/10ps
`default_nettype none
module tb_opcode_class_and_ea_check;
  import ocea_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ins_valid, user_mode, little_endian;
  logic [31:0] ins_word, ins_addr, gpr_a, gpr_b, link_reg, count_reg;
  logic dec_valid, dec_exec_ok, dec_prog_exc, dec_priv_exc, dec_align_exc;
  logic dec_is_mem, dec_is_branch, dec_misaligned;
  logic dec_wraps, dec_little_endian;
  logic [31:0] dec_exc_vector, dec_ea;
  logic [3:0] dec_op_len;
  ocea_class_e dec_class;
  ocea_ea_mode_e dec_ea_mode;
  int bad_count = 0;
  int checked = 0;

  always #4 ref_clk = ~ref_clk;

  ocea_fetch_model u_fetch (.ref_clk, .ins_valid, .ins_word, .ins_addr,
    .gpr_a, .gpr_b, .link_reg, .count_reg, .user_mode, .little_endian);
  ocea_decode u_dut (.ref_clk, .rst, .ins_valid, .ins_word, .ins_addr,
    .gpr_a, .gpr_b, .link_reg, .count_reg, .user_mode, .little_endian,
    .dec_valid, .dec_class, .dec_exec_ok, .dec_prog_exc, .dec_priv_exc,
    .dec_align_exc, .dec_exc_vector, .dec_is_mem, .dec_is_branch,
    .dec_ea_mode, .dec_op_len, .dec_ea, .dec_misaligned, .dec_wraps,
    .dec_little_endian);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_illegal();
    logic [5:0] wide [4] = '{6'h02, 6'h1E, 6'h3A, 6'h3E};
    u_fetch.issue(32'h0);
    chk(dec_class, OCEA_CLS_ILLEGAL);
    chk(dec_exc_vector, 32'h0000_0700);
    chk({dec_prog_exc, dec_exec_ok, dec_is_mem}, 32'h4);
    foreach (wide[i]) begin
      u_fetch.issue({wide[i], 26'h0});
      chk(dec_class, OCEA_CLS_ILLEGAL);
    end
    u_fetch.issue(32'h7C00_0002);
    chk(dec_class, OCEA_CLS_ILLEGAL);
    u_fetch.issue(32'h7C00_002A);
    chk(dec_class, OCEA_CLS_ILLEGAL);
  endtask

  task automatic t_reserved();
    u_fetch.issue(32'h0000_0001);
    chk(dec_class, OCEA_CLS_RSV_UNIMPL);
    chk(dec_prog_exc, 1'b1);
    u_fetch.issue(32'hFC00_002C);
    chk(dec_class, OCEA_CLS_RSV_UNIMPL);
    u_fetch.issue(32'hEC00_002C);
    chk(dec_class, OCEA_CLS_RSV_UNIMPL);
    u_fetch.issue(32'h7C00_07A4);
    chk(dec_class, OCEA_CLS_RSV_IMPL);
    u_fetch.issue(32'h7C00_07E4, 0, 0, 0, 0, 0, 1'b1);
    chk({dec_priv_exc, dec_exec_ok}, 32'h2);
    chk(dec_exc_vector, 32'h0000_0700);
    u_fetch.issue(32'h7C00_0214);
    chk({dec_class, dec_exec_ok}, 32'h1);
  endtask

  task automatic t_mem();
    u_fetch.issue(32'h8061_0004, 0, 32'hFFFF_FFFE);
    chk(dec_ea, 32'h2);
    chk({dec_is_mem, dec_misaligned, dec_wraps}, 32'h6);
    chk(dec_op_len, 4'h4);
    chk(dec_ea_mode, OCEA_EA_REG_IMM);
    u_fetch.issue(32'h8061_0000, 0, 32'hFFFF_FFFE);
    chk({dec_misaligned, dec_wraps}, 32'h3);
    u_fetch.issue(32'h8861_0003, 0, 32'h100, 0, 0, 0, 1'b0, 1'b1);
    chk(dec_ea, 32'h103);
    chk({dec_op_len, dec_misaligned}, 32'h2);
    chk(dec_little_endian, 1'b1);
    u_fetch.issue(32'h7C61_102E, 0, 32'h100, 32'h8);
    chk(dec_ea, 32'h108);
    chk(dec_ea_mode, OCEA_EA_REG_IDX);
    chk(dec_little_endian, 1'b0);
    u_fetch.issue(32'h7C61_24AA, 0, 32'h200);
    chk(dec_ea_mode, OCEA_EA_REG_IND);
    chk(dec_ea, 32'h200);
    u_fetch.issue(32'hC061_0000, 0, 32'h1001);
    chk({dec_align_exc, dec_exec_ok}, 32'h2);
    u_fetch.issue(32'h7C61_14AE, 0, 32'h100, 32'h2);
    chk({dec_align_exc, dec_op_len}, 5'h18);
  endtask

  task automatic t_branch();
    u_fetch.issue(32'h4800_0020, 32'hFFFF_FFF0);
    chk(dec_ea, 32'h10);
    chk({dec_is_branch, dec_ea_mode}, {1'b1, OCEA_EA_BR_REL});
    u_fetch.issue(32'h4800_0022, 32'h40);
    chk(dec_ea_mode, OCEA_EA_BR_ABS);
    chk(dec_ea, 32'h20);
    u_fetch.issue(32'h4C00_0020, 0, 0, 0, 32'h1237);
    chk(dec_ea_mode, OCEA_EA_BR_LR);
    chk(dec_ea, 32'h1234);
    u_fetch.issue(32'h4C00_0420, 0, 0, 0, 0, 32'h5679);
    chk(dec_ea_mode, OCEA_EA_BR_CTR);
    chk(dec_ea, 32'h5678);
  endtask

  // computed operands on every fetch line, mixing indexed loads and bclr
  task automatic t_sweep();
    logic [31:0] w;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] want;
    for (int i = 0; i < 8; i++) begin
      w = i[2] ? 32'h4C00_0020 : 32'h7C61_102E;
      a = 32'h0000_1000 << i;
      b = i;
      want = i[2] ? ((a + b) & 32'hFFFF_FFFC) : (a + b);
      u_fetch.issue(w, a, a, b, a + b, b, i[0], i[1]);
      chk(dec_ea, want);
      chk(dec_misaligned, !i[2] && b[1:0] != 2'h0);
      chk(dec_little_endian, i[1]);
      chk(dec_exec_ok, 1'b1);
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    chk({dec_valid, dec_class, dec_prog_exc}, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    t_illegal();
    t_reserved();
    t_mem();
    t_branch();
    t_sweep();
    @(posedge ref_clk);
    #1;
    chk({dec_valid, dec_exec_ok, dec_is_branch}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
